// ==== shared/slc_pkg.sv ====
package slc_pkg;

    // Geometry
    localparam int SEG_COUNT     = 4;
    localparam int SUB_COUNT     = 8;
    localparam int LONG_PER_SUB  = 4;
    localparam int TAG_W         = 22;
    localparam int LRU_W         = 2;
    localparam int ADDR_W        = 32;
    localparam int DATA_W        = 32;
    localparam int CACHE_BYTES   = 512;
    localparam int SEG_BYTES     = 128;

    // Bit-address field positions
    localparam int BIT_LSB_W     = 4;
    localparam int LONG_POS      = 5;
    localparam int SUB_POS       = 7;
    localparam int TAG_POS       = 10;
    localparam int WORD_POS      = 4;

    // Reset values
    localparam logic [TAG_W-1:0] TAG_RESET   = 22'h00_0000;
    localparam logic [1:0]       FILL_CNT_RESET = 2'h0;

    // Fetch request and answer
    typedef struct packed {
        logic              valid;
        logic [ADDR_W-1:0] addr;
    } slc_fetch_req_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] word;
    } slc_fetch_rsp_t;

    // Memory fill request and returned data
    typedef struct packed {
        logic              valid;
        logic [ADDR_W-1:0] addr;
    } slc_fill_req_t;

    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] data;
    } slc_fill_rsp_t;

endpackage : slc_pkg

// ==== core/slc_lru_stack.sv ====
`timescale 1ns/1ps
// Four-by-two recency stack; entry 0 is most recent, entry 3 least recent
module slc_lru_stack (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // Touch request
    input  wire logic       touch,
    input  wire logic [1:0] touch_seg,
    // Victim
    output logic [1:0]      victim_seg
);

    logic [1:0] stack_reg [0:3];
    logic [1:0] stack_next [0:3];
    logic [3:0] above;

    // Entry k is at or below the touched one if some entry at or above it matches
    assign above[0] = (stack_reg[0] == touch_seg);
    assign above[1] = above[0] | (stack_reg[1] == touch_seg);
    assign above[2] = above[1] | (stack_reg[2] == touch_seg);
    assign above[3] = above[2] | (stack_reg[3] == touch_seg);

    // Shift down the entries above the touched one, touched goes on top
    always_comb begin
        stack_next[0] = touch_seg;
        for (int k = 1; k < 4; k++) begin
            stack_next[k] = above[k-1] ? stack_reg[k] : stack_reg[k-1];
        end
    end

    assign victim_seg = stack_reg[3];

    // Reset ranks segment 0 most recent; any order is legal
    always_ff @(posedge core_clk) begin
        for (int k = 0; k < 4; k++) begin
            if (!rst_n) begin
                stack_reg[k] <= 2'(k);
            end else if (touch) begin
                stack_reg[k] <= stack_next[k];
            end
        end
    end

endmodule : slc_lru_stack

// ==== core/slc_icache.sv ====
`timescale 1ns/1ps
module slc_icache (
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    rst_n,
    // Host control
    input  wire logic                    host_flush,
    // Execution unit fetch port
    input  wire slc_pkg::slc_fetch_req_t fetch_req,
    output slc_pkg::slc_fetch_rsp_t      fetch_rsp,
    output logic                         fetch_ready,
    // Memory controller fill port
    output slc_pkg::slc_fill_req_t       fill_req,
    input  wire logic                    fill_ack,
    input  wire slc_pkg::slc_fill_rsp_t  fill_rsp
);

    ////////////////////////////////////////////////////////////////////////////
    // Storage

    typedef enum logic [2:0] {
        SLC_IDLE = 3'b001,
        SLC_REQ  = 3'b010,
        SLC_FILL = 3'b100
    } slc_state_t;

    localparam int LINES = slc_pkg::SEG_COUNT * slc_pkg::SUB_COUNT * slc_pkg::LONG_PER_SUB;

    // One long word per entry, indexed by segment, subsegment and long word
    logic [slc_pkg::DATA_W-1:0]   data_mem [0:LINES-1];
    logic [slc_pkg::TAG_W-1:0]    tag_reg [0:slc_pkg::SEG_COUNT-1];
    logic [slc_pkg::SUB_COUNT-1:0] present_reg [0:slc_pkg::SEG_COUNT-1];

    slc_state_t                   state_reg;
    slc_state_t                   state_next;
    // Fill bookkeeping, captured on the miss that starts it
    logic [1:0]                   fill_seg_reg;
    logic [1:0]                   fill_cnt_reg;
    logic [slc_pkg::ADDR_W-1:0]   miss_addr_reg;
    slc_pkg::slc_fetch_rsp_t      rsp_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode

    // Low four bits are the bit address inside a word and are ignored
    wire [slc_pkg::ADDR_W-1:0] word_addr = {fetch_req.addr[31:4], 4'h0};
    wire [slc_pkg::TAG_W-1:0]  req_tag   = word_addr[31:slc_pkg::TAG_POS];
    wire [2:0]                 req_sub   = word_addr[9:slc_pkg::SUB_POS];
    wire [1:0]                 req_long  = word_addr[6:slc_pkg::LONG_POS];
    wire                       req_half  = word_addr[slc_pkg::WORD_POS];

    function automatic logic [6:0] line_index(input logic [1:0] seg, input logic [2:0] sub,
                                              input logic [1:0] lw);
        line_index = {seg, sub, lw};
    endfunction : line_index

    ////////////////////////////////////////////////////////////////////////////
    // Lookup

    logic [3:0] tag_hit;
    logic [3:0] line_hit;
    logic [1:0] hit_seg;
    logic [1:0] tag_seg;

    // Compare every segment in parallel
    // After reset every tag reads zero; only present flags can make a hit
    always_comb begin
        hit_seg = 2'h0;
        tag_seg = 2'h0;
        for (int s = 0; s < slc_pkg::SEG_COUNT; s++) begin
            tag_hit[s]  = (tag_reg[s] == req_tag);
            line_hit[s] = tag_hit[s] & present_reg[s][req_sub];
            if (line_hit[s]) begin
                hit_seg = 2'(s);
            end
            if (tag_hit[s]) begin
                tag_seg = 2'(s);
            end
        end
    end

    wire any_hit  = |line_hit;
    wire any_tag  = |tag_hit;
    wire idle     = (state_reg == SLC_IDLE);
    wire hit_take = idle & fetch_req.valid & any_hit & ~host_flush;
    wire miss     = idle & fetch_req.valid & ~any_hit & ~host_flush;
    wire fill_beat = (state_reg == SLC_FILL) & fill_rsp.valid;
    wire fill_last = fill_beat & (fill_cnt_reg == 2'h3);

    // Subsegment of the pending fill, shared by the data write and the present set
    wire [2:0] fill_sub = miss_addr_reg[9:slc_pkg::SUB_POS];

    // Segment for the fill: reuse a matching tag, else the least recent
    wire [1:0] victim_seg;
    wire [1:0] alloc_seg = any_tag ? tag_seg : victim_seg;

    slc_lru_stack u_lru (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .touch      (hit_take),
        .touch_seg  (hit_seg),
        .victim_seg (victim_seg)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Control

    // Stalled fetches retry after the fill; the hit then serves them
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SLC_IDLE: begin
                if (miss) begin
                    state_next = SLC_REQ;
                end
            end
            SLC_REQ: begin
                if (fill_ack) begin
                    state_next = SLC_FILL;
                end
            end
            SLC_FILL: begin
                if (fill_last) begin
                    state_next = SLC_IDLE;
                end
            end
            default: begin
                state_next = SLC_IDLE;
            end
        endcase
    end

    assign fetch_ready    = hit_take;
    assign fetch_rsp      = rsp_reg;
    // Request stands from entering SLC_REQ until the acknowledge edge
    assign fill_req.valid = (state_reg == SLC_REQ);
    // Fill always starts at the first long word of the subsegment
    assign fill_req.addr  = {miss_addr_reg[31:slc_pkg::SUB_POS], 7'h00};

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_reg <= SLC_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Miss capture; a same-tag miss refills one subsegment of the segment it owns,
    // and the recency order waits until the retried fetch hits and touches it
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            fill_seg_reg  <= 2'h0;
            miss_addr_reg <= 32'h0000_0000;
        end else if (miss) begin
            fill_seg_reg  <= alloc_seg;
            miss_addr_reg <= word_addr;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n || miss) begin
            fill_cnt_reg <= slc_pkg::FILL_CNT_RESET;
        end else if (fill_beat) begin
            fill_cnt_reg <= fill_cnt_reg + 2'h1;
        end
    end

    // Data array has no reset; present flags guard it
    always_ff @(posedge core_clk) begin
        if (fill_beat) begin
            data_mem[line_index(fill_seg_reg, fill_sub, fill_cnt_reg)] <= fill_rsp.data;
        end
    end

    // Tags and present flags; a flush wins over a completing fill
    // Tags survive a flush, so only the present flags decide what is valid
    always_ff @(posedge core_clk) begin
        for (int s = 0; s < slc_pkg::SEG_COUNT; s++) begin
            if (!rst_n || host_flush) begin
                present_reg[s] <= 8'h00;
                if (!rst_n) begin
                    tag_reg[s] <= slc_pkg::TAG_RESET;
                end
            end else if (miss && !any_tag && 2'(s) == alloc_seg) begin
                tag_reg[s]     <= req_tag;
                present_reg[s] <= 8'h00;
            end else if (fill_last && 2'(s) == fill_seg_reg) begin
                present_reg[s][fill_sub] <= 1'b1;
            end
        end
    end

    // Registered answer word
    // Address bit four picks the upper instruction word of the long word
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rsp_reg <= '0;
        end else begin
            rsp_reg.valid <= hit_take;
            if (hit_take) begin
                rsp_reg.word <= req_half
                    ? data_mem[line_index(hit_seg, req_sub, req_long)][31:16]
                    : data_mem[line_index(hit_seg, req_sub, req_long)][15:0];
            end
        end
    end

endmodule : slc_icache

// ==== tb/slc_icache_assertions.sv ====
`timescale 1ns/1ps
module slc_icache_checker (
    // Clock and reset
    input wire logic                    core_clk,
    input wire logic                    rst_n,
    // Watched ports
    input wire logic                    host_flush,
    input wire slc_pkg::slc_fetch_req_t fetch_req,
    input wire slc_pkg::slc_fetch_rsp_t fetch_rsp,
    input wire logic                    fetch_ready,
    input wire slc_pkg::slc_fill_req_t  fill_req,
    input wire logic                    fill_ack,
    input wire slc_pkg::slc_fill_rsp_t  fill_rsp
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    // Fetch side
    a_rsp_after_take: assert property (fetch_ready |=> fetch_rsp.valid)
        else $error("answer missing after take");
    a_rsp_needs_take: assert property (fetch_rsp.valid |-> $past(fetch_ready))
        else $error("answer without take");
    a_flush_refuses: assert property (host_flush |-> !fetch_ready)
        else $error("fetch taken during flush");
    a_take_needs_req: assert property (fetch_ready |-> fetch_req.valid)
        else $error("take without request");
    ////////////////////////////////////////////////////////////////////////
    // Fill side; a hit must never overlap memory traffic
    a_hit_no_fill: assert property (fetch_ready |-> !fill_req.valid)
        else $error("fill during hit");
    a_fill_whole_sub: assert property (fill_req.valid |-> fill_req.addr[6:0] == 7'h00)
        else $error("fill not subsegment aligned");
    a_fill_for_miss: assert property (fill_req.valid |->
        fetch_req.valid && fill_req.addr[31:7] == fetch_req.addr[31:7])
        else $error("fill for unrequested address");
    a_fill_holds: assert property (fill_req.valid && !fill_ack |=>
        fill_req.valid && $stable(fill_req.addr))
        else $error("fill request dropped early");
    // Reset is checked while it is applied, so no disable here
    a_reset_quiet: assert property (disable iff (1'b0)
        !rst_n |=> !fill_req.valid && !fetch_rsp.valid)
        else $error("outputs active after reset");
    c_hit: cover property (fetch_ready);
    c_fill: cover property (fill_req.valid && fill_ack);
    c_flush: cover property (host_flush && fetch_req.valid);
endmodule : slc_icache_checker

bind slc_icache slc_icache_checker slc_icache_checker_inst (
    .core_clk(core_clk), .rst_n(rst_n), .host_flush(host_flush),
    .fetch_req(fetch_req), .fetch_rsp(fetch_rsp), .fetch_ready(fetch_ready),
    .fill_req(fill_req), .fill_ack(fill_ack), .fill_rsp(fill_rsp));

// ==== tb/slc_mem_model.sv ====
`timescale 1ns/1ps
module slc_mem_model (
    // Clock and reset
    input wire logic                   core_clk,
    input wire logic                   rst_n,
    // Mode
    input wire logic                   slow,
    // Fill port
    input wire slc_pkg::slc_fill_req_t fill_req,
    output logic                       fill_ack,
    output slc_pkg::slc_fill_rsp_t     fill_rsp,
    output logic [7:0]                 fill_count
);
    logic [2:0]  phase;
    logic [2:0]  wait_cnt;
    logic [31:0] base;
    logic [31:0] beat_addr;
    // Low half carries the long word's address, high half its inverse, so halves differ
    assign beat_addr = base + ((32'(phase) - 32'd1) << 5);
    initial begin
        fill_ack   = 1'b0;
        fill_rsp   = '0;
        fill_count = 8'h00;
        phase      = 3'd0;
        wait_cnt   = 3'd0;
    end
    // Ack after a delay, then four beats; data line toggles when idle
    always @(posedge core_clk) begin
        fill_ack       <= 1'b0;
        fill_rsp.valid <= 1'b0;
        fill_rsp.data  <= ~fill_rsp.data;
        if (!rst_n) begin
            phase    <= 3'd0;
            wait_cnt <= 3'd0;
        end else if (phase == 3'd0 && fill_req.valid && !fill_ack) begin
            if (wait_cnt == (slow ? 3'd5 : 3'd0)) begin
                fill_ack   <= 1'b1;
                base       <= fill_req.addr;
                phase      <= 3'd1;
                wait_cnt   <= 3'd0;
                fill_count <= fill_count + 8'h01;
            end else begin
                wait_cnt <= wait_cnt + 3'd1;
            end
        end else if (phase != 3'd0) begin
            // Beat in phase k carries long word k-1 of the subsegment
            fill_rsp.valid <= 1'b1;
            fill_rsp.data  <= {~beat_addr[15:0], beat_addr[15:0]};
            phase          <= (phase == 3'd4) ? 3'd0 : phase + 3'd1;
        end
    end
endmodule : slc_mem_model

// ==== tb/tb_slc_icache.sv ====
`timescale 1ns/1ps
module tb_slc_icache;
    logic                    core_clk;
    logic                    rst_n;
    logic                    host_flush;
    logic                    slow;
    slc_pkg::slc_fetch_req_t fetch_req;
    slc_pkg::slc_fetch_rsp_t fetch_rsp;
    logic                    fetch_ready;
    slc_pkg::slc_fill_req_t  fill_req;
    logic                    fill_ack;
    slc_pkg::slc_fill_rsp_t  fill_rsp;
    logic [7:0]              fill_count;
    int                      bad_count = 0;
    int                      checks = 0;
    // Tags 1..5 avoid tag 0, which every segment holds after reset
    logic [31:0] row_addr [12] = '{32'h0000_0400, 32'h0000_041f, 32'h0000_0460,
        32'h0000_0480, 32'h0000_0800, 32'h0000_0c00, 32'h0000_1000, 32'h0000_0400,
        32'h0000_1400, 32'h0000_0c00, 32'h0000_0800, 32'h0000_1000};
    logic [7:0]  row_fill [12] = '{8'h01, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01,
        8'h01, 8'h00, 8'h01, 8'h00, 8'h01, 8'h01};

    slc_icache slc_icache_inst (.core_clk(core_clk), .rst_n(rst_n),
        .host_flush(host_flush), .fetch_req(fetch_req), .fetch_rsp(fetch_rsp),
        .fetch_ready(fetch_ready), .fill_req(fill_req), .fill_ack(fill_ack),
        .fill_rsp(fill_rsp));
    slc_mem_model slc_mem_model_inst (.core_clk(core_clk), .rst_n(rst_n), .slow(slow),
        .fill_req(fill_req), .fill_ack(fill_ack), .fill_rsp(fill_rsp),
        .fill_count(fill_count));

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_of_test

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Word expected from the memory model: address low half, its inverse above
    function automatic logic [15:0] exp_word(input logic [31:0] a);
        logic [31:0] lw;
        lw = {a[31:5], 5'h00};
        return a[4] ? ~lw[15:0] : lw[15:0];
    endfunction : exp_word

    // Request held until taken; the answer is looked at one cycle later
    task automatic fetch(input logic [31:0] a, input logic [7:0] nf);
        int          n;
        logic [7:0]  f0;
        f0 = fill_count;
        fetch_req <= '{valid: 1'b1, addr: a};
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (fetch_ready !== 1'b1 && n < 200);
        if (n >= 200) begin
            bad_count++;
            end_of_test();
        end
        fetch_req <= '0;
        @(posedge core_clk);
        check("rsp_valid", 32'(fetch_rsp.valid), 32'h0000_0001);
        check("rsp_word", 32'(fetch_rsp.word), 32'(exp_word(a)));
        check("fills", 32'(fill_count - f0), 32'(nf));
    endtask : fetch

    initial begin
        rst_n      = 1'b0;
        host_flush = 1'b0;
        slow       = 1'b0;
        fetch_req  = '0;
        repeat (11) @(posedge core_clk);
        check("rst_ready", 32'(fetch_ready), 32'h0000_0000);
        check("rst_fill", 32'(fill_req.valid), 32'h0000_0000);
        check("rst_rsp", 32'(fetch_rsp.valid), 32'h0000_0000);
        $display("reset test done");
        @(posedge core_clk);
        rst_n <= 1'b1;
        // Misses, hits, subsegment refill and least-recent replacement
        for (int i = 0; i < 12; i++) begin
            fetch(row_addr[i], row_fill[i]);
        end
        $display("table test done");
        // Flush held with a pending hit request, then a slow refill
        host_flush <= 1'b1;
        fetch_req  <= '{valid: 1'b1, addr: 32'h0000_0c00};
        repeat (3) @(posedge core_clk);
        check("flush_ready", 32'(fetch_ready), 32'h0000_0000);
        host_flush <= 1'b0;
        slow       <= 1'b1;
        fetch(32'h0000_0c00, 8'h01);
        fetch(32'h0000_0c70, 8'h00);
        $display("flush test done");
        // Reset in mid-run must clear the present flags again, so this refills
        rst_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        check("mid_rst_ready", 32'(fetch_ready), 32'h0000_0000);
        check("mid_rst_fill", 32'(fill_req.valid), 32'h0000_0000);
        rst_n <= 1'b1;
        fetch(32'h0000_0c70, 8'h01);
        $display("reset again test done");
        end_of_test();
    end
endmodule : tb_slc_icache
